/* verif/bsscp_host_model.sv */
// bsscp_host_model: spi or i2c master driving the port pins
`timescale 1ns/1ns
module bsscp_host_model (
    input wire logic bus_data_oe_i, // device pulls data low
    input wire logic sdo_i, // spi read data
    input wire logic i2c_i, // mode in use
    output logic sclk_o, // clock, still between frames
    output logic cs_o, // select pin
    output logic sda_o // resolved data line
);
    logic drv = 1'b1;
    assign sda_o = drv & ~bus_data_oe_i; // open drain with pull-up
    initial begin
        sclk_o = 1'b1;
        cs_o = 1'b1;
    end
    // ====
    // bit and byte level
    task automatic bt(input logic b, output logic r);
        sclk_o = 1'b0;
        #40 drv = b;
        #40 r = i2c_i ? sda_o : sdo_i;
        sclk_o = 1'b1;
        #80;
    endtask : bt
    task automatic byt(input logic [7:0] b, input logic ab, output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) bt(b[i], r[i]);
        if (i2c_i) bt(ab, a);
    endtask : byt
    task automatic strt();
        drv = 1'b1;
        #80 drv = 1'b0;
        #80;
    endtask : strt
    task automatic stp();
        sclk_o = 1'b0;
        #40 drv = 1'b0;
        #40 sclk_o = 1'b1;
        #40 drv = 1'b1;
        #80;
    endtask : stp
    // ====
    // transactions
    task automatic spi(input logic [7:0] cmd, input int n, output logic [23:0] rd);
        logic [7:0] r;
        logic a;
        rd = 24'h00_0000;
        cs_o = 1'b0;
        #80 byt(cmd, 1'b1, r, a);
        for (int k = 0; k < n; k++) begin
            byt(8'hFF, 1'b0, r, a);
            rd = {rd[15:0], r};
        end
        #80 cs_o = 1'b1;
        drv = ~drv; // no stale data level
        #80;
    endtask : spi
    task automatic i2c(input logic p, input logic c, input logic [7:0] cmd, input int n,
        output logic [23:0] rd, output logic ok);
        logic [7:0] r;
        logic a;
        rd = 24'h00_0000;
        cs_o = p;
        strt();
        byt({6'h3B, c, 1'b0}, 1'b1, r, a);
        ok = ~a;
        byt(cmd, 1'b1, r, a);
        stp();
        if (n > 0) begin
            strt();
            byt({6'h3B, c, 1'b1}, 1'b1, r, a);
            ok = ok & ~a;
            for (int k = 1; k <= n; k++) begin
                byt(8'hFF, k == n, r, a);
                rd = {rd[15:0], r};
            end
            stp();
        end
    endtask : i2c
endmodule : bsscp_host_model

/* verif/bsscp_port_asserts.sv */
// bsscp_port_asserts: pin-level checks bound to the port
`timescale 1ns/1ns
module bsscp_port_asserts #(parameter int CONV_BASE_CYCLES = 1024) (
    input wire logic ref_clk_i, // core clock
    input wire logic reset_i, // async reset
    input wire logic serial_clock_i, // host clock pin
    input wire logic chip_select_pin_i, // select pin
    input wire logic protocol_select_pin_i, // mode pin
    input wire logic serial_out_pin_o, // spi data out
    input wire logic bus_data_oe_o, // i2c pull low
    input wire logic conversion_busy_o, // busy
    input wire logic result_ready_o // result held
);
    // ====
    // busy length counter
    localparam int B = CONV_BASE_CYCLES;
    logic [15:0] cnt_reg, cnt_next;
    always_comb cnt_next = conversion_busy_o ? cnt_reg + 16'h0001 : 16'h0000;
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) cnt_reg <= 16'h0000;
        else cnt_reg <= cnt_next;
    end
    // ====
    // properties
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_conv_done;
        $fell(conversion_busy_o) ##0 result_ready_o;
    endsequence
    a_spi_no_pull: assert property (!protocol_select_pin_i |-> !bus_data_oe_o)
        else $error("data pulled in spi mode");
    a_sdo_idle: assert property (!protocol_select_pin_i && chip_select_pin_i && $past(chip_select_pin_i, 4)
        |-> !serial_out_pin_o) else $error("spi out active while deselected");
    a_sdo_on_fall: assert property (!protocol_select_pin_i && $changed(serial_out_pin_o)
        |-> !serial_clock_i || chip_select_pin_i) else $error("spi out moved with clock high");
    a_done_gives_ready: assert property (!protocol_select_pin_i && $fell(conversion_busy_o) |-> result_ready_o)
        else $error("conversion ended without result");
    a_conv_length: assert property (s_conv_done |-> cnt_reg inside {[B:B+1], [2*B:2*B+1],
        [4*B:4*B+1], [8*B:8*B+1], [16*B:16*B+1]}) else $error("conversion length wrong");
    a_ready_cause: assert property ($rose(result_ready_o) |-> $past(conversion_busy_o))
        else $error("result without conversion");
    a_ready_by_link: assert property (!protocol_select_pin_i && $fell(result_ready_o) |-> !chip_select_pin_i)
        else $error("result dropped while deselected");
    a_ack_scl_low: assert property ($rose(bus_data_oe_o) |-> !serial_clock_i && $past(!serial_clock_i, 2))
        else $error("data pulled with clock high");
    a_oe_steady: assert property (serial_clock_i && $past(serial_clock_i, 4) |-> $stable(bus_data_oe_o))
        else $error("data moved while clock high");
endmodule : bsscp_port_asserts
bind bsscp_port bsscp_port_asserts #(.CONV_BASE_CYCLES(CONV_BASE_CYCLES)) chk_u (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .serial_clock_i(serial_clock_i), .chip_select_pin_i(chip_select_pin_i),
    .protocol_select_pin_i(protocol_select_pin_i), .serial_out_pin_o(serial_out_pin_o),
    .bus_data_oe_o(bus_data_oe_o), .conversion_busy_o(conversion_busy_o), .result_ready_o(result_ready_o));

/* verif/tb_top.sv */
// tb_top: self-checking bench for the serial command port
`timescale 1ns/1ns
module tb_top;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic ps = 1'b0;
    logic [23:0] pres = 24'h00_0000;
    logic [23:0] temp = 24'h00_0000;
    logic sclk, cs, sda, serial_out_pin, oe, busy, rdy, ok, dq;
    logic [23:0] rd;
    int n_fail = 0;
    int checked = 0;
    typedef struct {logic [7:0] cmd; int n; logic [23:0] exp;} bsscp_row_type;
    bsscp_row_type rows [10];
    always #4 ref_clk_i = ~ref_clk_i;
    bsscp_port #(.CONV_BASE_CYCLES(64)) dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .serial_clock_i(sclk),
        .chip_select_pin_i(cs), .protocol_select_pin_i(ps), .serial_in_or_bus_data_pin_i(sda),
        .serial_out_pin_o(serial_out_pin), .bus_data_out_o(dq), .bus_data_oe_o(oe), .raw_pressure_sample_i(pres),
        .raw_temperature_sample_i(temp), .conversion_busy_o(busy), .result_ready_o(rdy));
    bsscp_host_model host_u (.bus_data_oe_i(oe), .sdo_i(serial_out_pin), .i2c_i(ps), .sclk_o(sclk), .cs_o(cs), .sda_o(sda));
    // ====
    // helpers
    task automatic give_verdict();
        if (n_fail == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_idle();
        int i;
        for (i = 0; i < 4000 && busy !== 1'b0; i++) @(posedge ref_clk_i);
        #1;
        if (i == 4000) begin
            n_fail++;
            give_verdict();
        end
    endtask : wait_idle
    // ====
    // main sequence
    initial begin
        for (int i = 0; i < 8; i++) rows[i] = '{{4'hA, 3'(i), 1'b0}, 2, 24'(bsscp_pkg::CAL_INIT[16*i +: 16])};
        rows[8] = '{bsscp_pkg::CMD_ADC_READ, 3, 24'h00_0000};
        rows[9] = '{bsscp_pkg::CMD_RESET, 0, 24'h00_0000};
        repeat (3) @(posedge ref_clk_i);
        #1 reset_i = 1'b0;
        repeat (4) @(posedge ref_clk_i);
        #1;
        foreach (rows[i]) begin
            host_u.spi(rows[i].cmd, rows[i].n, rd);
            chk(rd, rows[i].exp);
        end
        for (int k = 0; k < 10; k++) begin
            pres = 24'h10_0000 + 24'(k);
            temp = 24'h20_0000 + 24'(k);
            host_u.spi({3'h2, 1'(k / 5), 3'(k % 5), 1'b0}, 0, rd);
            chk(24'(busy), 24'h00_0001);
            wait_idle();
            chk(24'(rdy), 24'h00_0001);
            host_u.spi(bsscp_pkg::CMD_ADC_READ, 3, rd);
            chk(rd, k < 5 ? pres : temp);
            host_u.spi(bsscp_pkg::CMD_ADC_READ, 3, rd);
            chk(rd, 24'h00_0000);
        end
        // mid-conversion read corrupts result
        host_u.spi(8'h48, 0, rd);
        host_u.spi(bsscp_pkg::CMD_ADC_READ, 3, rd);
        chk(rd, 24'h00_0000);
        wait_idle();
        host_u.spi(bsscp_pkg::CMD_ADC_READ, 3, rd);
        chk(rd, pres ^ bsscp_pkg::RESULT_CORRUPT_MASK);
        // mid-run reset, then i2c mode
        #1 reset_i = 1'b1;
        ps = 1'b1;
        repeat (3) @(posedge ref_clk_i);
        chk(24'({busy, rdy, oe, serial_out_pin}), 24'h00_0000);
        #1 reset_i = 1'b0;
        repeat (4) @(posedge ref_clk_i);
        #1;
        host_u.i2c(1'b1, 1'b1, 8'hA6, 2, rd, ok);
        chk({ok, rd[22:0]}, 24'h00_FFFF);
        host_u.i2c(1'b1, 1'b0, 8'hA6, 2, rd, ok);
        chk({ok, rd[22:0]}, {8'h80, bsscp_pkg::CAL_INIT[63:48]});
        host_u.i2c(1'b0, 1'b1, 8'hAE, 2, rd, ok);
        chk({ok, rd[22:0]}, {8'h80, bsscp_pkg::CAL_INIT[127:112]});
        host_u.i2c(1'b0, 1'b1, 8'h50, 0, rd, ok);
        wait_idle();
        host_u.i2c(1'b0, 1'b1, bsscp_pkg::CMD_ADC_READ, 3, rd, ok);
        chk(rd, temp);
        host_u.i2c(1'b0, 1'b1, 8'h48, 0, rd, ok);
        host_u.i2c(1'b0, 1'b1, bsscp_pkg::CMD_RESET, 0, rd, ok);
        chk({ok, 20'h0_0000, dq, busy, rdy}, 24'h80_0000);
        host_u.i2c(1'b0, 1'b1, bsscp_pkg::CMD_ADC_READ, 3, rd, ok);
        chk(rd, 24'h00_0000);
        give_verdict();
    end
endmodule : tb_top

/* verilog/bsscp_fifo.sv */
// bsscp_fifo: parameterised response FIFO with flush
`timescale 1ns/1ns
module bsscp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk_i, // core clock
    input wire logic reset_i, // async reset, active high
    bsscp_fifo_if.store fifo // push and pop sides
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);

    if (DEPTH < 2 || WIDTH < 1) begin : g_bad_param
        $error("bsscp_fifo: DEPTH must be at least 2 and WIDTH at least 1");
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0] count_reg, count_next;
    logic do_push, do_pop;

    assign fifo.push_ready = (count_reg != FULL_COUNT);
    assign fifo.pop_valid = (count_reg != '0);
    assign fifo.pop_data = mem_reg[rd_reg];
    assign do_push = fifo.push_valid && fifo.push_ready && !fifo.flush;
    assign do_pop = fifo.pop_ready && fifo.pop_valid && !fifo.flush;

    always_comb begin
        wr_next = wr_reg;
        rd_next = rd_reg;
        count_next = count_reg;
        if (fifo.flush) begin
            wr_next = '0;
            rd_next = '0;
            count_next = '0;
        end else begin
            if (do_push) begin
                wr_next = (wr_reg == LAST_SLOT) ? '0 : wr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_next = (rd_reg == LAST_SLOT) ? '0 : rd_reg + 1'b1;
            end
            if (do_push && !do_pop) begin
                count_next = count_reg + 1'b1;
            end else if (do_pop && !do_push) begin
                count_next = count_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_reg <= '0;
            rd_reg <= '0;
            count_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            count_reg <= count_next;
        end
    end

    // storage has no reset; a slot is only read after it was written
    always_ff @(posedge ref_clk_i) begin
        if (do_push) begin
            mem_reg[wr_reg] <= fifo.push_data;
        end
    end
endmodule : bsscp_fifo

/* verilog/bsscp_fifo_if.sv */
// bsscp_fifo_if: valid/ready byte stream between the command executor and the link
`timescale 1ns/1ns
interface bsscp_fifo_if #(parameter int WIDTH = 8);
    logic push_valid;
    logic push_ready;
    logic [WIDTH-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [WIDTH-1:0] pop_data;
    logic flush;
    modport fill (output push_valid, output push_data, output flush, input push_ready);
    modport drain (input pop_valid, input pop_data, output pop_ready);
    modport store (input push_valid, input push_data, input flush, input pop_ready,
                   output push_ready, output pop_valid, output pop_data);
endinterface : bsscp_fifo_if

/* verilog/bsscp_pkg.sv */
// bsscp_pkg: constants and types shared by the serial command port files
package bsscp_pkg;
    // =====================================================================
    // command byte layout
    localparam logic [7:0] CMD_RESET = 8'h1E;
    localparam logic [7:0] CMD_ADC_READ = 8'h00;
    localparam logic [2:0] CONV_PREFIX = 3'h2;
    localparam logic [3:0] PROM_PREFIX = 4'hA;
    localparam logic [2:0] OSR_MAX = 3'h4;
    // =====================================================================
    // link framing
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [2:0] SPI_LAST_BIT = 3'h7;
    localparam logic [5:0] BUS_ADDR_HIGH = 6'h3B;
    localparam logic [1:0] PROM_RESP_BYTES = 2'h2;
    localparam logic [1:0] ADC_RESP_BYTES = 2'h3;
    // =====================================================================
    // data
    localparam int PROM_WORDS = 8;
    localparam int PROM_WORD_W = 16;
    localparam int RESULT_W = 24;
    // arbitrary contents; word 7 ends in a 4-bit check nibble
    localparam logic [127:0] CAL_INIT = 128'h5A3C_0B41_6D2E_7F10_1234_5678_9ABC_0001;
    localparam logic [23:0] RESULT_CORRUPT_MASK = 24'hA5_A5A5;
    localparam logic [23:0] RESULT_NONE = 24'h00_0000;
    // =====================================================================
    // state machines
    typedef enum logic [2:0] {
        LK_IDLE, LK_ADDR, LK_ADDR_ACK, LK_WRITE, LK_WRITE_ACK, LK_READ, LK_READ_ACK
    } bsscp_link_type;
    typedef enum logic {EX_IDLE, EX_PUSH} bsscp_exec_type;
endpackage : bsscp_pkg

/* verilog/bsscp_port.sv */
// bsscp_port: serial command port of a barometric sensor, spi or i2c slave
`timescale 1ns/1ns
module bsscp_port #(
    parameter int CONV_BASE_CYCLES = 1024,
    parameter logic [127:0] CAL_WORDS = bsscp_pkg::CAL_INIT,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic ref_clk_i, // core clock, 125 MHz
    input wire logic reset_i, // async reset, active high
    input wire logic serial_clock_i, // serial clock pin from host
    input wire logic chip_select_pin_i, // spi select (low active) or inverted i2c address bit
    input wire logic protocol_select_pin_i, // high i2c, low spi
    input wire logic serial_in_or_bus_data_pin_i, // spi data in or i2c data level
    output logic serial_out_pin_o, // spi read data
    output logic bus_data_out_o, // i2c data drive level, always low
    output logic bus_data_oe_o, // high while pulling i2c data low
    input wire logic [23:0] raw_pressure_sample_i, // pressure converter value
    input wire logic [23:0] raw_temperature_sample_i, // temperature converter value
    output logic conversion_busy_o, // conversion in progress
    output logic result_ready_o // an unread result is held
);
    localparam int CONV_CNT_W = $clog2(CONV_BASE_CYCLES * 16 + 1);

    if (CONV_BASE_CYCLES < 1 || CONV_BASE_CYCLES > 65536 || FIFO_DEPTH < 3) begin : g_bad_param
        $error("bsscp_port: CONV_BASE_CYCLES or FIFO_DEPTH out of range");
    end

    // =====================================================================
    // pin synchronisers
    logic [3:0] sync1_reg, sync2_reg;
    logic scl_d_reg, sda_d_reg;
    logic scl, sda, cs_n, bus_mode;
    logic scl_rise, scl_fall, bus_start, bus_stop;

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            scl_d_reg <= 1'b0;
            sda_d_reg <= 1'b0;
        end else begin
            sync1_reg <= {protocol_select_pin_i, chip_select_pin_i, serial_in_or_bus_data_pin_i, serial_clock_i};
            sync2_reg <= sync1_reg;
            scl_d_reg <= sync2_reg[0];
            sda_d_reg <= sync2_reg[1];
        end
    end

    assign scl = sync2_reg[0];
    assign sda = sync2_reg[1];
    assign cs_n = sync2_reg[2];
    assign bus_mode = sync2_reg[3];
    assign scl_rise = scl && !scl_d_reg;
    assign scl_fall = !scl && scl_d_reg;
    assign bus_start = scl && scl_d_reg && sda_d_reg && !sda;
    assign bus_stop = scl && scl_d_reg && !sda_d_reg && sda;

    // =====================================================================
    // response fifo
    bsscp_fifo_if #(.WIDTH(8)) resp_if ();

    bsscp_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .fifo(resp_if.store)
    );

    // =====================================================================
    // link state
    bsscp_pkg::bsscp_link_type lk_reg, lk_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] sh_in_reg, sh_in_next;
    logic [7:0] sh_out_reg, sh_out_next;
    logic rw_reg, rw_next;
    logic nack_reg, nack_next;
    logic got_cmd_reg, got_cmd_next;
    logic sdo_reg, sdo_next;
    logic oe_reg, oe_next;
    logic sda_out_reg;
    logic cmd_valid_reg, cmd_valid_next;
    logic [7:0] cmd_reg, cmd_next;
    logic load_byte;
    logic [7:0] next_byte;
    logic [7:0] in_byte;
    logic ex_ready;

    // reads past the queued answer give zero
    assign next_byte = resp_if.pop_valid ? resp_if.pop_data : 8'h00;
    assign resp_if.pop_ready = load_byte;
    assign in_byte = {sh_in_reg[6:0], sda};

    always_comb begin
        lk_next = lk_reg;
        cnt_next = cnt_reg;
        sh_in_next = sh_in_reg;
        sh_out_next = sh_out_reg;
        rw_next = rw_reg;
        nack_next = nack_reg;
        got_cmd_next = got_cmd_reg;
        sdo_next = sdo_reg;
        oe_next = oe_reg;
        cmd_valid_next = 1'b0;
        cmd_next = cmd_reg;
        load_byte = 1'b0;
        if (!bus_mode) begin
            oe_next = 1'b0;
            lk_next = bsscp_pkg::LK_IDLE;
            if (cs_n) begin
                cnt_next = '0;
                got_cmd_next = 1'b0;
                sdo_next = 1'b0;
            end else if (scl_rise) begin
                sh_in_next = in_byte;
                cnt_next = {1'b0, cnt_reg[2:0] + 3'h1};
                if (!got_cmd_reg && cnt_reg[2:0] == bsscp_pkg::SPI_LAST_BIT) begin
                    got_cmd_next = 1'b1;
                    cmd_valid_next = 1'b1;
                    cmd_next = in_byte;
                end
            end else if (scl_fall && got_cmd_reg) begin
                if (cnt_reg[2:0] == 3'h0) begin
                    load_byte = 1'b1;
                    sdo_next = next_byte[7];
                    sh_out_next = {next_byte[6:0], 1'b0};
                end else begin
                    sdo_next = sh_out_reg[7];
                    sh_out_next = {sh_out_reg[6:0], 1'b0};
                end
            end
        end else if (bus_start) begin
            lk_next = bsscp_pkg::LK_ADDR;
            cnt_next = '0;
            oe_next = 1'b0;
        end else if (bus_stop) begin
            lk_next = bsscp_pkg::LK_IDLE;
            oe_next = 1'b0;
        end else begin
            unique case (lk_reg)
                bsscp_pkg::LK_IDLE: begin
                    oe_next = 1'b0;
                end
                bsscp_pkg::LK_ADDR: begin
                    if (scl_rise) begin
                        sh_in_next = in_byte;
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == bsscp_pkg::BYTE_BITS) begin
                        if (sh_in_reg[7:1] == {bsscp_pkg::BUS_ADDR_HIGH, !cs_n}) begin
                            oe_next = 1'b1;
                            rw_next = sh_in_reg[0];
                            lk_next = bsscp_pkg::LK_ADDR_ACK;
                        end else begin
                            lk_next = bsscp_pkg::LK_IDLE;
                        end
                    end
                end
                bsscp_pkg::LK_ADDR_ACK: begin
                    if (scl_fall) begin
                        cnt_next = '0;
                        if (rw_reg) begin
                            load_byte = 1'b1;
                            oe_next = !next_byte[7];
                            sh_out_next = {next_byte[6:0], 1'b0};
                            lk_next = bsscp_pkg::LK_READ;
                        end else begin
                            oe_next = 1'b0;
                            lk_next = bsscp_pkg::LK_WRITE;
                        end
                    end
                end
                bsscp_pkg::LK_WRITE: begin
                    if (scl_rise) begin
                        sh_in_next = in_byte;
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == bsscp_pkg::BYTE_BITS) begin
                        // a busy executor nacks, except for reset
                        if (ex_ready || sh_in_reg == bsscp_pkg::CMD_RESET) begin
                            cmd_valid_next = 1'b1;
                            cmd_next = sh_in_reg;
                            oe_next = 1'b1;
                        end
                        lk_next = bsscp_pkg::LK_WRITE_ACK;
                    end
                end
                bsscp_pkg::LK_WRITE_ACK: begin
                    if (scl_fall) begin
                        oe_next = 1'b0;
                        cnt_next = '0;
                        lk_next = bsscp_pkg::LK_WRITE;
                    end
                end
                bsscp_pkg::LK_READ: begin
                    if (scl_rise) begin
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_reg == bsscp_pkg::BYTE_BITS) begin
                            oe_next = 1'b0;
                            lk_next = bsscp_pkg::LK_READ_ACK;
                        end else begin
                            oe_next = !sh_out_reg[7];
                            sh_out_next = {sh_out_reg[6:0], 1'b0};
                        end
                    end
                end
                bsscp_pkg::LK_READ_ACK: begin
                    if (scl_rise) begin
                        nack_next = sda;
                    end else if (scl_fall) begin
                        cnt_next = '0;
                        if (!nack_reg) begin
                            load_byte = 1'b1;
                            oe_next = !next_byte[7];
                            sh_out_next = {next_byte[6:0], 1'b0};
                            lk_next = bsscp_pkg::LK_READ;
                        end else begin
                            lk_next = bsscp_pkg::LK_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            lk_reg <= bsscp_pkg::LK_IDLE;
            cnt_reg <= '0;
            sh_in_reg <= '0;
            sh_out_reg <= '0;
            rw_reg <= 1'b0;
            nack_reg <= 1'b0;
            got_cmd_reg <= 1'b0;
            sdo_reg <= 1'b0;
            oe_reg <= 1'b0;
            sda_out_reg <= 1'b0;
            cmd_valid_reg <= 1'b0;
            cmd_reg <= '0;
        end else begin
            lk_reg <= lk_next;
            cnt_reg <= cnt_next;
            sh_in_reg <= sh_in_next;
            sh_out_reg <= sh_out_next;
            rw_reg <= rw_next;
            nack_reg <= nack_next;
            got_cmd_reg <= got_cmd_next;
            sdo_reg <= sdo_next;
            oe_reg <= oe_next;
            sda_out_reg <= 1'b0;
            cmd_valid_reg <= cmd_valid_next;
            cmd_reg <= cmd_next;
        end
    end

    // =====================================================================
    // command executor and conversion timer
    bsscp_pkg::bsscp_exec_type ex_reg, ex_next;
    logic [23:0] resp_reg, resp_next;
    logic [1:0] left_reg, left_next;
    logic busy_reg, busy_next;
    logic conv_temp_reg, conv_temp_next;
    logic corrupt_reg, corrupt_next;
    logic [CONV_CNT_W-1:0] conv_cnt_reg, conv_cnt_next;
    logic [23:0] result_reg, result_next;
    logic valid_reg, valid_next;
    logic reset_cmd;
    logic is_conv, is_prom;
    logic [15:0] prom_word;
    logic [23:0] sample;

    assign ex_ready = (ex_reg == bsscp_pkg::EX_IDLE);
    assign is_conv = (cmd_reg[7:5] == bsscp_pkg::CONV_PREFIX) && !cmd_reg[0]
                     && (cmd_reg[3:1] <= bsscp_pkg::OSR_MAX);
    assign is_prom = (cmd_reg[7:4] == bsscp_pkg::PROM_PREFIX) && !cmd_reg[0];
    assign prom_word = CAL_WORDS[{cmd_reg[3:1], 4'h0} +: bsscp_pkg::PROM_WORD_W];
    assign sample = conv_temp_reg ? raw_temperature_sample_i : raw_pressure_sample_i;
    assign reset_cmd = cmd_valid_reg && cmd_reg == bsscp_pkg::CMD_RESET;
    // spi frame end or reset command drops any queued answer
    assign resp_if.flush = (!bus_mode && cs_n) || reset_cmd;
    assign resp_if.push_valid = (ex_reg == bsscp_pkg::EX_PUSH);
    assign resp_if.push_data = resp_reg[23:16];

    always_comb begin
        ex_next = ex_reg;
        resp_next = resp_reg;
        left_next = left_reg;
        busy_next = busy_reg;
        conv_temp_next = conv_temp_reg;
        corrupt_next = corrupt_reg;
        conv_cnt_next = conv_cnt_reg;
        result_next = result_reg;
        valid_next = valid_reg;
        if (busy_reg) begin
            if (conv_cnt_reg == '0) begin
                busy_next = 1'b0;
                valid_next = 1'b1;
                result_next = corrupt_reg ? (sample ^ bsscp_pkg::RESULT_CORRUPT_MASK) : sample;
            end else begin
                conv_cnt_next = conv_cnt_reg - 1'b1;
            end
        end
        if (ex_reg == bsscp_pkg::EX_PUSH && resp_if.push_ready) begin
            resp_next = {resp_reg[15:0], 8'h00};
            left_next = left_reg - 2'h1;
            if (left_reg == 2'h1) begin
                ex_next = bsscp_pkg::EX_IDLE;
            end
        end
        if (reset_cmd) begin
            ex_next = bsscp_pkg::EX_IDLE;
            busy_next = 1'b0;
            corrupt_next = 1'b0;
            valid_next = 1'b0;
        end else if (cmd_valid_reg) begin
            if (is_conv) begin
                if (busy_reg) begin
                    corrupt_next = 1'b1;
                end else begin
                    busy_next = 1'b1;
                    corrupt_next = 1'b0;
                    conv_temp_next = cmd_reg[4];
                    conv_cnt_next = CONV_CNT_W'((CONV_BASE_CYCLES << cmd_reg[3:1]) - 1);
                end
            end else if (cmd_reg == bsscp_pkg::CMD_ADC_READ) begin
                resp_next = (valid_reg && !busy_reg) ? result_reg : bsscp_pkg::RESULT_NONE;
                valid_next = 1'b0;
                if (busy_reg) begin
                    corrupt_next = 1'b1;
                end
                left_next = bsscp_pkg::ADC_RESP_BYTES;
                ex_next = bsscp_pkg::EX_PUSH;
            end else if (is_prom) begin
                resp_next = {prom_word, 8'h00};
                left_next = bsscp_pkg::PROM_RESP_BYTES;
                ex_next = bsscp_pkg::EX_PUSH;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ex_reg <= bsscp_pkg::EX_IDLE;
            resp_reg <= '0;
            left_reg <= '0;
            busy_reg <= 1'b0;
            conv_temp_reg <= 1'b0;
            corrupt_reg <= 1'b0;
            conv_cnt_reg <= '0;
            result_reg <= '0;
            valid_reg <= 1'b0;
        end else begin
            ex_reg <= ex_next;
            resp_reg <= resp_next;
            left_reg <= left_next;
            busy_reg <= busy_next;
            conv_temp_reg <= conv_temp_next;
            corrupt_reg <= corrupt_next;
            conv_cnt_reg <= conv_cnt_next;
            result_reg <= result_next;
            valid_reg <= valid_next;
        end
    end

    // =====================================================================
    // outputs
    assign serial_out_pin_o = sdo_reg;
    assign bus_data_out_o = sda_out_reg;
    assign bus_data_oe_o = oe_reg;
    assign conversion_busy_o = busy_reg;
    assign result_ready_o = valid_reg;
endmodule : bsscp_port
